// File: shared/csj_pkg.sv
package csj_pkg;
	localparam int XLEN = 32;
	localparam int ILEN = 16;
	localparam int PC_STEP = 2;
	localparam int SKIP_STEP = 4;
	localparam int SKIP_PFX_STEP = 6;
	localparam int RF_DEPTH = 32;
	localparam int RIDX_W = 5;
	// Register indices
	localparam logic [4:0] LINK_REG_IDX = 5'h0F;
	localparam logic [4:0] STACK_PTR_IDX = 5'h0E;
	localparam logic [4:0] BASE_REG_OFS = 5'h10;
	// Opcode patterns (top bits)
	localparam logic [5:0] OP_EXEC_IF_BIT_SET = 6'h14;
	localparam logic [5:0] OP_LOAD_INDIRECT = 6'h16;
	localparam logic [2:0] OP_LOAD_STACK = 3'h7;
	localparam logic [3:0] OP_LOAD_BASE = 4'hB;
	localparam logic [10:0] OP_EXEC_IF_NZ = 11'h3F6;
	localparam logic [10:0] OP_EXEC_IF_Z = 11'h3FA;
	localparam logic [10:0] OP_JUMP = 11'h3FE;
	localparam logic [11:0] OP_SKIP_COND = 12'h7EE;
	localparam logic [15:0] OP_LINK_RETURN = 16'h7FCF;
	localparam logic [4:0] OP_PREFIX = 5'h13;
	localparam logic [4:0] OP_PREFIX_UNC = 5'h12;
endpackage

// File: core/csj_regfile.sv
`timescale 1ns/1ps
module csj_regfile
	import csj_pkg::*;
(
	input wire logic clk_in,
	input wire logic ce_in,
	input wire logic [4:0] raddr_in,
	output logic [31:0] rdata_out,
	input wire logic we_in,
	input wire logic [4:0] waddr_in,
	input wire logic [31:0] wdata_in
);
	// Start cleared so a read before any load is a defined zero
	logic [31:0] mem_q [RF_DEPTH] = '{default: 32'h0000_0000};
	// Registered read; callers wait one cycle per operand
	always_ff @(posedge clk_in) begin
		if (ce_in) begin
			rdata_out <= mem_q[raddr_in];
			if (we_in) begin
				mem_q[waddr_in] <= wdata_in;
			end
		end
	end
endmodule

// File: core/csj_core.sv
`timescale 1ns/1ps
// How it works
// - Bit-test: skip next when selected register-A bit is 0.
// - Skip adds 4 to PC, or 6 if next is a prefix.
// - Nonzero test skips next when register A equals zero.
// - Zero test skips next when register A is nonzero.
// - Condition execute: run next if flag condition true, else skip.
// - Selectors 0..7: nc, c, nz, z, pl, mi, lt, ge.
// - Selectors 8..d: gt, le, nv, v, hi, ls.
// - No instruction in this group touches the N V Z C flags.
// - Computed jump: PC gets register A shifted left one.
// - One delay-slot instruction runs after a jump, before target.
// - Link return jumps to link register shifted left one.
// - Indirect load reads word at register B bits 31..2.
// - Prefixed indirect load adds sign-extended prefix times four.
// - Cached loads may be served by the data cache.
// - Uncached prefix: same address, but the load bypasses cache.
// - Base-relative load: aligned base plus 5-bit immediate times four.
// - Base field picks one of four registers, index minus 16.
// - Prefixed base load: sign-extended prefix:imm times four.
// - Stack load: aligned stack pointer plus 8-bit immediate times four.
// - Software keeps delay-slot instruction restrictions.
module csj_core
	import csj_pkg::*;
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	output logic [31:0] imem_addr_out,
	output logic imem_req_out,
	input wire logic imem_valid_in,
	input wire logic [15:0] imem_data_in,
	output logic [31:0] dmem_addr_out,
	output logic dmem_req_out,
	output logic dmem_uncached_out,
	input wire logic dmem_valid_in,
	input wire logic [31:0] dmem_data_in,
	input wire logic [3:0] flags_in,
	output logic [3:0] flags_out,
	output logic [31:0] pc_out,
	output logic [10:0] prefix_k_out,
	output logic illegal_out
);
	typedef enum logic [2:0] {
		CSJ_FETCH, CSJ_DECODE, CSJ_RD_A, CSJ_RD_B, CSJ_PEEK, CSJ_LOAD,
		CSJ_WB
	} csj_state_t;

	////////////////////////////////////////////////////////////////////////
	function automatic logic cond_true(input logic [3:0] sel,
		input logic [3:0] f);
		logic n;
		logic v;
		logic z;
		logic c;
		logic lt;
		n = f[3];
		v = f[2];
		z = f[1];
		c = f[0];
		lt = n ^ v;
		case (sel)
			4'h0: cond_true = !c;
			4'h1: cond_true = c;
			4'h2: cond_true = !z;
			4'h3: cond_true = z;
			4'h4: cond_true = !n;
			4'h5: cond_true = n;
			4'h6: cond_true = lt;
			4'h7: cond_true = !lt;
			4'h8: cond_true = !(z | lt);
			4'h9: cond_true = z | lt;
			4'hA: cond_true = !v;
			4'hB: cond_true = v;
			4'hC: cond_true = !(c | z);
			4'hD: cond_true = c | z;
			default: cond_true = 1'b0;
		endcase
	endfunction

	function automatic logic is_prefix(input logic [15:0] ins);
		is_prefix = (ins[15:11] == OP_PREFIX) ||
			(ins[15:11] == OP_PREFIX_UNC);
	endfunction

	function automatic logic [31:0] word_addr(input logic [31:0] base,
		input logic [31:0] ofs_words);
		word_addr = {base[31:2], 2'b00} + {ofs_words[29:0], 2'b00};
	endfunction

	////////////////////////////////////////////////////////////////////////
	csj_state_t state_q;
	csj_state_t state_d;
	logic [31:0] pc_q;
	logic [15:0] ir_q;
	logic [10:0] k_q;
	logic pfx_q;
	logic pfx_unc_q;
	logic [31:0] jtgt_q;
	logic slot_q;
	logic [31:0] ra_q;
	logic [31:0] rdat;
	logic [4:0] rf_raddr;
	logic rf_we;
	logic [31:0] imem_addr_q;
	logic imem_req_q;
	logic [31:0] dmem_addr_q;
	logic dmem_req_q;
	logic dmem_unc_q;
	logic illegal_q;

	// Instruction fields
	wire logic [4:0] fld_a = ir_q[4:0];
	wire logic [4:0] fld_b = ir_q[9:5];
	wire logic [4:0] short_immediate = ir_q[9:5];
	wire logic [3:0] condition_select_field = ir_q[3:0];
	wire logic [7:0] stack_offset_field = ir_q[12:5];
	wire logic [1:0] fld_p = ir_q[11:10];

	wire logic dec_bit = ir_q[15:10] == OP_EXEC_IF_BIT_SET;
	wire logic dec_nz = ir_q[15:5] == OP_EXEC_IF_NZ;
	wire logic dec_z = ir_q[15:5] == OP_EXEC_IF_Z;
	wire logic dec_cc = ir_q[15:4] == OP_SKIP_COND;
	wire logic dec_ret = ir_q == OP_LINK_RETURN;
	wire logic dec_jmp = (ir_q[15:5] == OP_JUMP) && !dec_ret;
	wire logic dec_ld = ir_q[15:10] == OP_LOAD_INDIRECT;
	wire logic dec_ldp = ir_q[15:12] == OP_LOAD_BASE;
	wire logic dec_lds = ir_q[15:13] == OP_LOAD_STACK;
	wire logic dec_pfx = is_prefix(ir_q);
	wire logic dec_load = dec_ld | dec_ldp | dec_lds;
	wire logic dec_skipgrp = dec_bit | dec_nz | dec_z | dec_cc;

	// Skip decisions, on register A value once read or on live flags
	wire logic skip_bit = !ra_q[short_immediate];
	wire logic skip_nz = ra_q == 32'h0000_0000;
	wire logic skip_z = ra_q != 32'h0000_0000;
	wire logic skip_cc = !cond_true(condition_select_field, flags_in);
	wire logic skip_now = (dec_bit & skip_bit) | (dec_nz & skip_nz) |
		(dec_z & skip_z);

	// Operand A register index for the read phase
	wire logic [4:0] idx_a = dec_ret ? LINK_REG_IDX :
		(dec_lds ? STACK_PTR_IDX :
		(dec_ldp ? (BASE_REG_OFS + {3'b000, fld_p}) :
		(dec_ld ? fld_b : fld_a)));

	// Load offsets in words
	wire logic [31:0] ofs_ld = pfx_q ? {{21{k_q[10]}}, k_q} : 32'h0;
	wire logic [15:0] k_imm = {k_q, short_immediate};
	wire logic [31:0] ofs_ldp = pfx_q ? {{16{k_imm[15]}}, k_imm} :
		{27'h0, short_immediate};
	wire logic [31:0] ofs_lds = {24'h0, stack_offset_field};
	wire logic [31:0] ofs_sel = dec_ld ? ofs_ld :
		(dec_ldp ? ofs_ldp : ofs_lds);

	wire logic [31:0] pc_seq = pc_q + 32'(PC_STEP);
	// Slot done: next fetch goes to the stored target
	// Slot content is trusted: restricted kinds are not trapped here
	wire logic [31:0] pc_next = slot_q ? jtgt_q : pc_seq;

	assign rf_raddr = idx_a;
	assign rf_we = ce_in && (state_q == CSJ_LOAD) && dmem_valid_in;

	csj_regfile u_rf (
		.clk_in(clk_in),
		.ce_in(ce_in),
		.raddr_in(rf_raddr),
		.rdata_out(rdat),
		.we_in(rf_we),
		.waddr_in(fld_a),
		.wdata_in(dmem_data_in)
	);

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_d = state_q;
		case (state_q)
			CSJ_FETCH: if (imem_valid_in) state_d = CSJ_DECODE;
			CSJ_DECODE: state_d = CSJ_RD_A;
			CSJ_RD_A: state_d = CSJ_RD_B;
			CSJ_RD_B: begin
				if (dec_load) state_d = CSJ_LOAD;
				else if (dec_skipgrp) state_d = CSJ_PEEK;
				else state_d = CSJ_FETCH;
			end
			CSJ_PEEK: if (imem_valid_in) state_d = CSJ_FETCH;
			CSJ_LOAD: if (dmem_valid_in) state_d = CSJ_FETCH;
			default: state_d = CSJ_FETCH;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			state_q <= CSJ_FETCH;
		end else if (ce_in) begin
			state_q <= state_d;
		end
	end

	// Fetch, decode and execute; flags pass through untouched
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			pc_q <= 32'h0000_0000;
			ir_q <= 16'h0000;
			k_q <= 11'h000;
			pfx_q <= 1'b0;
			pfx_unc_q <= 1'b0;
			jtgt_q <= 32'h0000_0000;
			slot_q <= 1'b0;
			ra_q <= 32'h0000_0000;
			imem_addr_q <= 32'h0000_0000;
			imem_req_q <= 1'b1;
			dmem_addr_q <= 32'h0000_0000;
			dmem_req_q <= 1'b0;
			dmem_unc_q <= 1'b0;
			illegal_q <= 1'b0;
		end else if (ce_in) begin
			case (state_q)
				CSJ_FETCH: begin
					if (imem_valid_in) begin
						ir_q <= imem_data_in;
						imem_req_q <= 1'b0;
					end
				end
				CSJ_DECODE: begin
					illegal_q <= !(dec_skipgrp | dec_jmp | dec_ret |
						dec_load | dec_pfx);
				end
				CSJ_RD_B: begin
					ra_q <= rdat;
					if (dec_pfx) begin
						k_q <= ir_q[10:0];
						pfx_q <= 1'b1;
						pfx_unc_q <= ir_q[15:11] == OP_PREFIX_UNC;
					end
					if (dec_load) begin
						dmem_addr_q <= word_addr(rdat, ofs_sel);
						dmem_req_q <= 1'b1;
						// Only the uncached prefix steers around the cache
						dmem_unc_q <= pfx_q & pfx_unc_q;
					end else if (dec_skipgrp) begin
						imem_addr_q <= pc_q + 32'(PC_STEP);
						imem_req_q <= 1'b1;
					end else begin
						if (dec_jmp | dec_ret) begin
							jtgt_q <= {rdat[30:0], 1'b0};
							slot_q <= 1'b1;
						end else begin
							slot_q <= 1'b0;
						end
						pc_q <= pc_next;
						imem_addr_q <= pc_next;
						imem_req_q <= 1'b1;
						if (!dec_pfx) pfx_q <= 1'b0;
					end
				end
				CSJ_PEEK: begin
					if (imem_valid_in) begin
						// Test uses operand held in ra_q, flags live
						if (skip_now | (dec_cc & skip_cc)) begin
							pc_q <= pc_q + (is_prefix(imem_data_in) ?
								32'(SKIP_PFX_STEP) : 32'(SKIP_STEP));
							imem_addr_q <= pc_q + (is_prefix(imem_data_in) ?
								32'(SKIP_PFX_STEP) : 32'(SKIP_STEP));
							slot_q <= 1'b0;
						end else begin
							pc_q <= pc_next;
							imem_addr_q <= pc_next;
							slot_q <= 1'b0;
						end
						pfx_q <= 1'b0;
						imem_req_q <= 1'b1;
					end
				end
				CSJ_LOAD: begin
					if (dmem_valid_in) begin
						dmem_req_q <= 1'b0;
						pfx_q <= 1'b0;
						pc_q <= pc_next;
						imem_addr_q <= pc_next;
						imem_req_q <= 1'b1;
						slot_q <= 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Flags are reflected, never modified by this group
	logic [3:0] flags_q;
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			flags_q <= 4'h0;
		end else if (ce_in) begin
			flags_q <= flags_in;
		end
	end

	assign flags_out = flags_q;
	assign pc_out = pc_q;
	assign prefix_k_out = k_q;
	assign illegal_out = illegal_q;
	assign imem_addr_out = imem_addr_q;
	assign imem_req_out = imem_req_q;
	assign dmem_addr_out = dmem_addr_q;
	assign dmem_req_out = dmem_req_q;
	assign dmem_uncached_out = dmem_unc_q;

	////////////////////////////////////////////////////////////////////////
	sequence s_jump_issue;
		state_q == CSJ_RD_B && (dec_jmp | dec_ret);
	endsequence

	AST_JUMP_SLOT: assert property (@(posedge clk_in) disable iff (srst_in)
		(ce_in and s_jump_issue)
		|=> slot_q && pc_q == $past(pc_q) + 32'(PC_STEP))
		else $error("delay slot not next after jump");
	AST_JUMP_TGT: assert property (@(posedge clk_in) disable iff (srst_in)
		ce_in && state_q == CSJ_RD_B && dec_jmp |=> jtgt_q[0] == 1'b0
		&& jtgt_q == {$past(rdat[30:0]), 1'b0})
		else $error("jump target not register shifted left");
	AST_RET_LINK: assert property (@(posedge clk_in) disable iff (srst_in)
		state_q == CSJ_RD_B && dec_ret |-> rf_raddr == LINK_REG_IDX)
		else $error("return not through link register");
	AST_SKIP_STEP: assert property (@(posedge clk_in) disable iff (srst_in)
		ce_in && state_q == CSJ_PEEK && imem_valid_in && skip_now
		&& !is_prefix(imem_data_in) |=> pc_q == $past(pc_q) + 32'(SKIP_STEP))
		else $error("skip did not advance PC by 4");
	AST_SKIP_PFX: assert property (@(posedge clk_in) disable iff (srst_in)
		ce_in && state_q == CSJ_PEEK && imem_valid_in && skip_now
		&& is_prefix(imem_data_in) |=> pc_q == $past(pc_q) + 32'(SKIP_PFX_STEP))
		else $error("skip over prefix did not advance PC by 6");
	AST_BIT_SKIP: assert property (@(posedge clk_in) disable iff (srst_in)
		ce_in && state_q == CSJ_PEEK && imem_valid_in && dec_bit && !slot_q
		&& !is_prefix(imem_data_in) |=> pc_q == $past(pc_q)
		+ ($past(ra_q[short_immediate]) ? 32'(PC_STEP) : 32'(SKIP_STEP)))
		else $error("bit test decision wrong");
	AST_LD_ALIGN: assert property (@(posedge clk_in) disable iff (srst_in)
		ce_in && state_q == CSJ_RD_B && dec_ld && !pfx_q
		|=> dmem_addr_q == {$past(rdat[31:2]), 2'b00})
		else $error("indirect load address not aligned base");
	AST_UNCACHED: assert property (@(posedge clk_in) disable iff (srst_in)
		ce_in && state_q == CSJ_RD_B && dec_load
		|=> dmem_uncached_out == $past(pfx_q & pfx_unc_q))
		else $error("cache bypass mismatch");
	AST_FLAGS: assert property (@(posedge clk_in) disable iff (srst_in)
		ce_in |=> flags_out == $past(flags_in))
		else $error("flags altered");
endmodule

// File: bench/csj_mem_model.sv
`timescale 1ns/1ps
module csj_mem_model (
	input wire logic clk_in,
	input wire logic [31:0] imem_addr_in,
	input wire logic imem_req_in,
	output logic imem_valid_out,
	output logic [15:0] imem_data_out,
	input wire logic [31:0] dmem_addr_in,
	input wire logic dmem_req_in,
	input wire logic dmem_uncached_in,
	output logic dmem_valid_out,
	output logic [31:0] dmem_data_out
);
	logic [15:0] prog [0:255];
	logic [31:0] dq [$];
	logic [31:0] la [$];
	logic lu [$];
	int lat = 0;
	int ic = 0;
	int dc = 0;

	initial begin
		imem_valid_out = 1'b0;
		imem_data_out = 16'h0000;
		dmem_valid_out = 1'b0;
		dmem_data_out = 32'h0000_0000;
	end

	////////////////////////////////////////////////////////////////////////
	// Idle buses toggle so stale data never passes for an answer
	always @(posedge clk_in) begin
		imem_valid_out <= 1'b0;
		imem_data_out <= ~imem_data_out;
		if (imem_req_in && !imem_valid_out) begin
			if (ic >= lat) begin
				imem_valid_out <= 1'b1;
				imem_data_out <= prog[imem_addr_in[8:1]];
				ic <= 0;
			end else begin
				ic <= ic + 1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Each answered load is logged for the bench to judge
	always @(posedge clk_in) begin
		dmem_valid_out <= 1'b0;
		dmem_data_out <= ~dmem_data_out;
		if (dmem_req_in && !dmem_valid_out) begin
			if (dc >= lat) begin
				dmem_valid_out <= 1'b1;
				dmem_data_out <= (dq.size() > 0) ? dq.pop_front() : 32'h0;
				la.push_back(dmem_addr_in);
				lu.push_back(dmem_uncached_in);
				dc <= 0;
			end else begin
				dc <= dc + 1;
			end
		end
	end
endmodule

// File: bench/csj_core_tb.sv
`timescale 1ns/1ps
module csj_core_tb;
	import csj_pkg::*;
	logic clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic ce_in = 1'b1;
	logic [3:0] flags_in = 4'h0;
	logic [31:0] ia, da, idat32, dd, pc;
	logic ireq, iv, dreq, dunc, dv, ill;
	logic [15:0] id;
	logic [3:0] flags_out;
	logic [10:0] pk;
	int n_mismatch = 0;
	int samples_checked = 0;
	int wp;
	logic [31:0] ea [$];
	logic eu [$];

	csj_core i_csj_core (.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce_in),
		.imem_addr_out(ia), .imem_req_out(ireq), .imem_valid_in(iv),
		.imem_data_in(id), .dmem_addr_out(da), .dmem_req_out(dreq),
		.dmem_uncached_out(dunc), .dmem_valid_in(dv), .dmem_data_in(dd),
		.flags_in(flags_in), .flags_out(flags_out), .pc_out(pc),
		.prefix_k_out(pk), .illegal_out(ill));
	csj_mem_model i_csj_mem_model (.clk_in(clk_in), .imem_addr_in(ia),
		.imem_req_in(ireq), .imem_valid_out(iv), .imem_data_out(id),
		.dmem_addr_in(da), .dmem_req_in(dreq), .dmem_uncached_in(dunc),
		.dmem_valid_out(dv), .dmem_data_out(dd));

	initial begin
		forever #2.5 clk_in = ~clk_in;
	end

	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic put(input logic [15:0] w);
		i_csj_mem_model.prog[wp] = w;
		wp++;
	endtask

	// Expected load: address, cache bypass, data handed back
	task automatic exp_ld(input logic [31:0] a, input logic u,
		input logic [31:0] d);
		ea.push_back(a);
		eu.push_back(u);
		i_csj_mem_model.dq.push_back(d);
	endtask

	// Marker load: stack pointer is zero, so address is four times n
	task automatic mark(input logic [7:0] n, input logic runs);
		put({OP_LOAD_STACK, n, 5'h01});
		if (runs) begin
			exp_ld({22'h0, n, 2'h0}, 1'b0, 32'h0);
		end
	endtask

	// First load sets the stack pointer; its address is not yet known
	task automatic boot(input logic [31:0] sp);
		@(posedge clk_in);
		srst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		for (int i = 0; i < 256; i++) begin
			i_csj_mem_model.prog[i] = 16'h0000;
		end
		i_csj_mem_model.la.delete();
		i_csj_mem_model.lu.delete();
		i_csj_mem_model.dq.delete();
		ea.delete();
		eu.delete();
		wp = 0;
		put({OP_LOAD_INDIRECT, 5'h00, 5'h0E});
		i_csj_mem_model.dq.push_back(sp);
	endtask

	task automatic run(input int lat, input string name);
		int k;
		int n;
		i_csj_mem_model.lat = lat;
		@(posedge clk_in);
		srst_in <= 1'b0;
		k = 0;
		while (i_csj_mem_model.la.size() <= ea.size() && k < 800) begin
			@(posedge clk_in);
			k++;
		end
		repeat (10) @(posedge clk_in);
		n = i_csj_mem_model.la.size();
		chk("load_count", 32'(n), 32'(ea.size() + 1));
		for (int i = 0; i < ea.size() && i + 1 < n; i++) begin
			chk("load_addr", i_csj_mem_model.la[i + 1], ea[i]);
			chk("load_uncached", {31'h0, i_csj_mem_model.lu[i + 1]},
				{31'h0, eu[i]});
		end
		$display("Test %s done", name);
	endtask

	function automatic logic cc_true(input logic [3:0] s,
		input logic [3:0] f);
		logic t;
		case (s[3:1])
			3'h0: t = f[0];
			3'h1: t = f[1];
			3'h2: t = f[3];
			3'h3: t = !(f[3] ^ f[2]);
			3'h4: t = f[1] | (f[3] ^ f[2]);
			3'h5: t = f[2];
			default: t = f[0] | f[1];
		endcase
		return t ~^ s[0];
	endfunction

	task automatic t_loads();
		boot(32'h0000_1003);
		put({OP_LOAD_INDIRECT, 5'h0E, 5'h10});
		exp_ld(32'h0000_1000, 1'b0, 32'h0000_2002);
		put({OP_LOAD_INDIRECT, 5'h0E, 5'h13});
		exp_ld(32'h0000_1000, 1'b0, 32'h0000_3001);
		put({OP_LOAD_STACK, 8'hFF, 5'h01});
		exp_ld(32'h0000_13FC, 1'b0, 32'h0);
		put({OP_PREFIX, 11'h7FF});
		put({OP_LOAD_INDIRECT, 5'h0E, 5'h02});
		exp_ld(32'h0000_0FFC, 1'b0, 32'h0);
		put({OP_PREFIX_UNC, 11'h007});
		put({OP_LOAD_INDIRECT, 5'h10, 5'h02});
		exp_ld(32'h0000_201C, 1'b1, 32'h0);
		put({OP_LOAD_BASE, 2'h3, 5'h1F, 5'h03});
		exp_ld(32'h0000_307C, 1'b0, 32'h0);
		put({OP_PREFIX, 11'h7FF});
		put({OP_LOAD_BASE, 2'h0, 5'h1F, 5'h03});
		exp_ld(32'h0000_1FFC, 1'b0, 32'h0);
		run(3, "loads");
		chk("prefix_k", {21'h0, pk}, 32'h0000_07FF);
	endtask

	task automatic t_skips();
		boot(32'h0);
		put({OP_LOAD_INDIRECT, 5'h0E, 5'h04});
		exp_ld(32'h0, 1'b0, 32'h0000_0080);
		put({OP_LOAD_INDIRECT, 5'h0E, 5'h05});
		exp_ld(32'h0, 1'b0, 32'h0);
		put({OP_EXEC_IF_BIT_SET, 5'h07, 5'h04});
		mark(8'h01, 1'b1);
		put({OP_EXEC_IF_BIT_SET, 5'h06, 5'h04});
		mark(8'h02, 1'b0);
		mark(8'h03, 1'b1);
		put({OP_EXEC_IF_NZ, 5'h05});
		put({OP_PREFIX, 11'h7FF});
		mark(8'h04, 1'b0);
		mark(8'h05, 1'b1);
		put({OP_EXEC_IF_Z, 5'h05});
		mark(8'h06, 1'b1);
		put({OP_EXEC_IF_Z, 5'h04});
		mark(8'h07, 1'b0);
		put({OP_EXEC_IF_NZ, 5'h04});
		mark(8'h08, 1'b1);
		run(0, "skips");
	endtask

	task automatic t_cond(input logic [3:0] f);
		boot(32'h0);
		flags_in <= f;
		for (int s = 0; s < 14; s++) begin
			put({OP_SKIP_COND, 4'(s)});
			mark(8'(s + 1), cc_true(4'(s), f));
		end
		run(1, "conditions");
		chk("flags_out", {28'h0, flags_out}, {28'h0, f});
	endtask

	// Bit 31 of the jump register must fall off in the shift
	task automatic t_jump();
		logic [31:0] p;
		boot(32'h0);
		put({OP_LOAD_INDIRECT, 5'h0E, 5'h06});
		exp_ld(32'h0, 1'b0, 32'h8000_0040);
		put({OP_LOAD_INDIRECT, 5'h0E, 5'h0F});
		exp_ld(32'h0, 1'b0, 32'h0000_0060);
		put({OP_JUMP, 5'h06});
		mark(8'h01, 1'b1);
		mark(8'h02, 1'b0);
		wp = 8'h40;
		mark(8'h03, 1'b1);
		put(OP_LINK_RETURN);
		mark(8'h04, 1'b1);
		mark(8'h05, 1'b0);
		wp = 8'h60;
		mark(8'h06, 1'b1);
		run(1, "jumps");
		chk("illegal", {31'h0, ill}, 32'h0000_0001);
		// Freeze while only zero words run, so no load is in flight
		@(posedge clk_in);
		ce_in <= 1'b0;
		@(posedge clk_in);
		p = pc;
		repeat (6) @(posedge clk_in);
		chk("pc_frozen", pc, p);
		ce_in <= 1'b1;
	endtask

	initial begin
		repeat (20000) @(posedge clk_in);
		n_mismatch++;
		$display("Error watchdog expected finish seen hang");
		summarize();
	end

	initial begin
		repeat (20) @(posedge clk_in);
		t_loads();
		t_skips();
		t_cond(4'h0);
		t_cond(4'hB);
		t_cond(4'h4);
		t_jump();
		summarize();
	end
endmodule
